// *** hw/dpb_pkg.sv ***
package dpb_pkg;

    // ************************************************************
    // Banks and command field layout
    // ************************************************************
    localparam int unsigned NUM_BANKS      = 4;
    localparam int unsigned BANK_W         = 2;
    localparam int unsigned CNT_W          = 8;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] CFG_OFFSET      = 8'h00;
    localparam logic [7:0] TIMING_OFFSET   = 8'h04;
    localparam logic [7:0] BANK_OFFSET     = 8'h08;
    localparam logic [7:0] VIOL_OFFSET     = 8'h0c;

    // Configuration field positions
    localparam int unsigned CFG_BL8_BIT    = 0;
    localparam int unsigned CFG_ADD_LSB    = 4;
    localparam int unsigned CFG_COL_LSB    = 8;
    localparam int unsigned CFG_WR_LSB     = 12;

    // Timing field positions (cycles)
    localparam int unsigned TIM_RAS_LSB    = 0;
    localparam int unsigned TIM_RP_LSB     = 8;
    localparam int unsigned TIM_R2P_LSB    = 16;
    localparam int unsigned TIM_RC_LSB     = 24;

    // Violation flag positions
    localparam int unsigned VIO_INTR_BIT   = 0;
    localparam int unsigned VIO_SPACE_BIT  = 1;
    localparam int unsigned VIO_PRE_BIT    = 2;
    localparam int unsigned VIO_ACT_BIT    = 3;
    localparam int unsigned VIO_W          = 4;

    // Reset values: burst of eight, additive 0, column 3, recovery 3,
    // active minimum 9, precharge 3, read-to-precharge 2, row cycle 12
    localparam logic [31:0] CFG_RESET      = 32'h0000_3301;
    localparam logic [31:0] TIMING_RESET   = 32'h0c02_0309;

    // Fixed timing counts
    localparam logic [CNT_W-1:0] CCD_CYC   = 8'h02;
    localparam logic [CNT_W-1:0] PREF_GAP  = 8'h02;
    localparam logic [CNT_W-1:0] BL8_HALF  = 8'h04;
    localparam logic [CNT_W-1:0] BL4_HALF  = 8'h02;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE
    } dpb_cmd_type;

    typedef struct packed {
        dpb_cmd_type       cmd;
        logic [BANK_W-1:0] bank;
        logic              ap_all;
    } dpb_req_type;

endpackage : dpb_pkg

// *** hw/dpb_top.sv ***
// How it works
// - Interrupting command may address any bank.
// - Read may be cut by read with auto-precharge, write likewise.
// - Spacing uses programmed burst length, not the shortened burst.
// - Write recovery starts after the uninterrupted burst end.
// - Precharge closes bank from two bank bits, or all banks when bit high.
// - Column command bit high closes the bank after the burst.
// - Read auto-precharge at additive latency plus half, held for active and read-precharge minima.
// - Delayed auto-precharge starts precharge period where read-precharge minimum ends.
// - Read auto-precharge not before two clocks after the last prefetch.
// - Write auto-precharge starts after data stored plus recovery cycles.
// - Auto-precharge is held off until active-to-precharge minimum passes.
// - Read latency is additive plus column; write latency is one less.
`timescale 1ns/1ps
`default_nettype none

module dpb_top (
    // Clock and reset
    input  wire logic                     CLK,
    input  wire logic                     RST_B,
    // DRAM command, already in the clock domain
    input  wire dpb_pkg::dpb_req_type     CMD_REQ,
    // AHB-Lite slave
    input  wire logic                     HSEL,
    input  wire logic [31:0]              HADDR,
    input  wire logic [1:0]               HTRANS,
    input  wire logic                     HWRITE,
    input  wire logic [2:0]               HSIZE,
    input  wire logic [31:0]              HWDATA,
    input  wire logic                     HREADY,
    output var  logic [31:0]              HRDATA,
    output var  logic                     HREADYOUT,
    output var  logic                     HRESP,
    // Bank state
    output var  logic [3:0]               BANK_OPEN,
    output var  logic [3:0]               BANK_PRECHARGING
);

    // ************************************************************
    // Configuration fields
    // ************************************************************
    logic [31:0] cfg_reg;
    logic [31:0] timing_reg;
    logic [dpb_pkg::VIO_W-1:0] viol_reg;
    logic [dpb_pkg::VIO_W-1:0] viol_next;
    logic                      bl8;
    logic [dpb_pkg::CNT_W-1:0] additive_latency, column_latency, write_recovery;
    logic [dpb_pkg::CNT_W-1:0] read_latency, write_latency, half_len;
    logic [dpb_pkg::CNT_W-1:0] ras_cyc, rp_cyc, read_to_precharge_cycles, rc_cyc;
    logic [dpb_pkg::CNT_W-1:0] rd_pre_gap, wr_pre_gap, rd_ap_gap, r2p_eff, prefetch_pt;

    assign bl8                      = cfg_reg[dpb_pkg::CFG_BL8_BIT];
    assign additive_latency         = {4'h0, cfg_reg[dpb_pkg::CFG_ADD_LSB +: 4]};
    assign column_latency           = {4'h0, cfg_reg[dpb_pkg::CFG_COL_LSB +: 4]};
    assign write_recovery           = {4'h0, cfg_reg[dpb_pkg::CFG_WR_LSB +: 4]};
    assign ras_cyc                  = timing_reg[dpb_pkg::TIM_RAS_LSB +: 8];
    assign rp_cyc                   = timing_reg[dpb_pkg::TIM_RP_LSB +: 8];
    assign read_to_precharge_cycles = timing_reg[dpb_pkg::TIM_R2P_LSB +: 8];
    assign rc_cyc                   = timing_reg[dpb_pkg::TIM_RC_LSB +: 8];

    // Derived latencies, and gaps from the programmed burst length
    assign read_latency  = additive_latency + column_latency;
    assign write_latency = read_latency - 8'h01;
    assign half_len      = bl8 ? dpb_pkg::BL8_HALF : dpb_pkg::BL4_HALF;
    assign r2p_eff       = (read_to_precharge_cycles > dpb_pkg::PREF_GAP) ?
                           read_to_precharge_cycles : dpb_pkg::PREF_GAP;
    assign rd_pre_gap    = additive_latency + half_len + r2p_eff - 8'h02;
    assign wr_pre_gap    = write_latency + half_len + write_recovery;
    // Last prefetch point: additive latency, plus 2 for a burst of eight
    assign prefetch_pt   = additive_latency + (bl8 ? 8'h02 : 8'h00);
    // Read auto-precharge: later of nominal edge and prefetch plus read-to-precharge
    assign rd_ap_gap     = ((additive_latency + half_len) > (prefetch_pt + r2p_eff)) ?
        (additive_latency + half_len) : (prefetch_pt + r2p_eff);

    // ************************************************************
    // Column command spacing and burst interrupt tracking
    // ************************************************************
    logic [dpb_pkg::CNT_W-1:0] col_age_reg;
    logic                      burst_rd_reg, burst_ap_reg, burst_live_reg;
    logic                      is_col, is_rd, is_wr, is_pre, is_act;

    assign is_rd  = (CMD_REQ.cmd == dpb_pkg::CMD_RD);
    assign is_wr  = (CMD_REQ.cmd == dpb_pkg::CMD_WR);
    assign is_pre = (CMD_REQ.cmd == dpb_pkg::CMD_PRE);
    assign is_act = (CMD_REQ.cmd == dpb_pkg::CMD_ACT);
    assign is_col = is_rd | is_wr;

    // Age of the last column command and whether its burst is still running
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            col_age_reg    <= 8'hff;
            burst_rd_reg   <= 1'b0;
            burst_ap_reg   <= 1'b0;
            burst_live_reg <= 1'b0;
        end else if (is_col) begin
            col_age_reg    <= 8'h01;
            burst_rd_reg   <= is_rd;
            burst_ap_reg   <= CMD_REQ.ap_all;
            burst_live_reg <= 1'b1;
        end else begin
            if (col_age_reg != 8'hff) begin
                col_age_reg <= col_age_reg + 8'h01;
            end
            if (col_age_reg >= half_len) begin
                burst_live_reg <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Per-bank timers
    // ************************************************************
    logic [3:0] open_reg, pchg_reg, ap_pend_reg;
    logic [dpb_pkg::CNT_W-1:0] act_age_reg [dpb_pkg::NUM_BANKS];
    logic [dpb_pkg::CNT_W-1:0] pre_age_reg [dpb_pkg::NUM_BANKS];
    logic [dpb_pkg::CNT_W-1:0] ap_wait_reg [dpb_pkg::NUM_BANKS];
    logic [dpb_pkg::CNT_W-1:0] pre_ok_reg  [dpb_pkg::NUM_BANKS];
    logic [3:0] pre_hit, ap_start, pre_early, act_early;

    // Precharge bank decode: one bank from bank bits, or all
    always_comb begin
        pre_hit = 4'h0;
        if (is_pre) begin
            if (CMD_REQ.ap_all) begin
                pre_hit = 4'hf;
            end else begin
                pre_hit[CMD_REQ.bank] = 1'b1;
            end
        end
    end

    for (genvar b = 0; b < dpb_pkg::NUM_BANKS; b++) begin : g_bank
        localparam logic [dpb_pkg::BANK_W-1:0] BANK_ID = dpb_pkg::BANK_W'(b);
        logic hit_col;
        assign hit_col = is_col && (CMD_REQ.bank == BANK_ID);
        // Auto-precharge fires when its wait ends and active minimum is met
        assign ap_start[b]  = ap_pend_reg[b] && (ap_wait_reg[b] <= 8'h01) &&
                              (act_age_reg[b] >= ras_cyc);
        assign pre_early[b] = pre_hit[b] && open_reg[b] &&
                              ((act_age_reg[b] < ras_cyc) || (pre_ok_reg[b] != 8'h00));
        assign act_early[b] = is_act && (CMD_REQ.bank == BANK_ID) &&
                              ((pchg_reg[b] && (pre_age_reg[b] < rp_cyc)) ||
                               (act_age_reg[b] < rc_cyc) || ap_pend_reg[b]);

        // Bank open/precharging state and independent timers
        always_ff @(posedge CLK or negedge RST_B) begin
            if (!RST_B) begin
                open_reg[b]    <= 1'b0;
                pchg_reg[b]    <= 1'b0;
                ap_pend_reg[b] <= 1'b0;
                act_age_reg[b] <= 8'hff;
                pre_age_reg[b] <= 8'hff;
                ap_wait_reg[b] <= 8'h00;
                pre_ok_reg[b]  <= 8'h00;
            end else begin
                if (act_age_reg[b] != 8'hff) begin
                    act_age_reg[b] <= act_age_reg[b] + 8'h01;
                end
                if (pre_age_reg[b] != 8'hff) begin
                    pre_age_reg[b] <= pre_age_reg[b] + 8'h01;
                end
                if (ap_wait_reg[b] > 8'h01) begin
                    ap_wait_reg[b] <= ap_wait_reg[b] - 8'h01;
                end
                if (pre_ok_reg[b] != 8'h00) begin
                    pre_ok_reg[b] <= pre_ok_reg[b] - 8'h01;
                end
                if (is_act && (CMD_REQ.bank == BANK_ID)) begin
                    open_reg[b]    <= 1'b1;
                    pchg_reg[b]    <= 1'b0;
                    act_age_reg[b] <= 8'h01;
                end else if (pre_hit[b] || ap_start[b]) begin
                    open_reg[b]    <= 1'b0;
                    pchg_reg[b]    <= 1'b1;
                    ap_pend_reg[b] <= 1'b0;
                    pre_age_reg[b] <= 8'h01;
                end else if (hit_col) begin
                    // Earliest legal explicit precharge from this column command
                    pre_ok_reg[b] <= (is_rd ? rd_pre_gap : wr_pre_gap) - 8'h01;
                    if (CMD_REQ.ap_all) begin
                        ap_pend_reg[b] <= 1'b1;
                        ap_wait_reg[b] <= is_rd ? rd_ap_gap :
                                          (wr_pre_gap);
                    end
                end
            end
        end
    end

    // ************************************************************
    // Protocol violation flags (sticky, set wins over clear)
    // ************************************************************
    logic interrupting, bad_interrupt, bad_space;
    logic bus_wr_viol;
    logic [31:0] bus_wdata_clr;

    assign interrupting  = burst_live_reg && (col_age_reg < half_len) &&
                           (is_col || is_pre);
    // Any bank may interrupt; type, length, auto-precharge and gap are checked
    assign bad_interrupt = interrupting &&
                           (!bl8 ||
                            (burst_rd_reg && !is_rd) ||
                            (!burst_rd_reg && !is_wr) ||
                            burst_ap_reg ||
                            (col_age_reg != dpb_pkg::CCD_CYC));
    assign bad_space     = is_col && (col_age_reg < dpb_pkg::CCD_CYC);

    always_comb begin
        viol_next = viol_reg;
        if (bus_wr_viol) begin
            viol_next = viol_reg & ~bus_wdata_clr[dpb_pkg::VIO_W-1:0];
        end
        if (bad_interrupt) viol_next[dpb_pkg::VIO_INTR_BIT]  = 1'b1;
        if (bad_space)     viol_next[dpb_pkg::VIO_SPACE_BIT] = 1'b1;
        if (|pre_early)    viol_next[dpb_pkg::VIO_PRE_BIT]   = 1'b1;
        if (|act_early)    viol_next[dpb_pkg::VIO_ACT_BIT]   = 1'b1;
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) viol_reg <= '0;
        else        viol_reg <= viol_next;
    end

    // ************************************************************
    // AHB-Lite slave, zero wait states
    // ************************************************************
    logic       dp_wr_reg, dp_rd_reg;
    logic [7:0] dp_addr_reg;
    logic       addr_ok;

    assign addr_ok       = HSEL && HREADY && HTRANS[1];
    assign bus_wr_viol   = dp_wr_reg && (dp_addr_reg == dpb_pkg::VIOL_OFFSET);
    assign bus_wdata_clr = HWDATA;

    // Capture address phase
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            dp_wr_reg   <= 1'b0;
            dp_rd_reg   <= 1'b0;
            dp_addr_reg <= 8'h00;
        end else begin
            dp_wr_reg   <= addr_ok && HWRITE;
            dp_rd_reg   <= addr_ok && !HWRITE;
            dp_addr_reg <= HADDR[7:0];
        end
    end

    // Register writes in the data phase
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            cfg_reg    <= dpb_pkg::CFG_RESET;
            timing_reg <= dpb_pkg::TIMING_RESET;
        end else if (dp_wr_reg) begin
            if (dp_addr_reg == dpb_pkg::CFG_OFFSET) begin
                cfg_reg <= HWDATA & 32'h0000_fff1;
            end else if (dp_addr_reg == dpb_pkg::TIMING_OFFSET) begin
                timing_reg <= HWDATA;
            end
        end
    end

    // Read data registered at the address phase edge
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            HRDATA <= 32'h0000_0000;
        end else if (addr_ok && !HWRITE) begin
            if (HADDR[7:0] == dpb_pkg::CFG_OFFSET) begin
                HRDATA <= cfg_reg;
            end else if (HADDR[7:0] == dpb_pkg::TIMING_OFFSET) begin
                HRDATA <= timing_reg;
            end else if (HADDR[7:0] == dpb_pkg::BANK_OFFSET) begin
                HRDATA <= {24'h0, pchg_reg, open_reg};
            end else if (HADDR[7:0] == dpb_pkg::VIOL_OFFSET) begin
                HRDATA <= {28'h0, viol_next};
            end else begin
                HRDATA <= 32'h0000_0000;
            end
        end
    end

    // Always ready, always OKAY; bank status outputs
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            HREADYOUT        <= 1'b1;
            HRESP            <= 1'b0;
            BANK_OPEN        <= 4'h0;
            BANK_PRECHARGING <= 4'h0;
        end else begin
            HREADYOUT        <= 1'b1;
            HRESP            <= 1'b0;
            BANK_OPEN        <= open_reg;
            BANK_PRECHARGING <= pchg_reg;
        end
    end

endmodule : dpb_top

`default_nettype wire

// *** test/dpb_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Memory controller model driving the command port
// ************************************************************
module dpb_ctrl_model (
    // Clock
    input  wire logic             CLK,
    // Command towards the device
    output var dpb_pkg::dpb_req_type CMD_REQ
);
    // Idle command at time zero
    initial CMD_REQ = {dpb_pkg::CMD_NOP, 2'h0, 1'b0};

    // Issue one command; the next one may follow gap cycles later
    task send(input dpb_pkg::dpb_cmd_type cmd, input logic [1:0] bank, input logic ap,
              input int gap);
        CMD_REQ <= {cmd, bank, ap};
        for (int i = 0; i < gap; i++) begin
            @(posedge CLK);
            if (i == 0 && gap > 1) CMD_REQ <= {dpb_pkg::CMD_NOP, 2'h0, 1'b0};
        end
    endtask : send

    // Earliest read to precharge gap, from the programmed length
    function automatic int rd_to_pre(input int add_lat, input int half, input int r2p);
        return add_lat + half + ((r2p > 2) ? r2p : 2) - 2;
    endfunction : rd_to_pre

    // Earliest write to precharge gap; write latency is one below read latency
    function automatic int wr_to_pre(input int add_lat, input int col_lat, input int half,
                                     input int rec);
        return (add_lat + col_lat - 1) + half + rec;
    endfunction : wr_to_pre
endmodule : dpb_ctrl_model
`default_nettype wire

// *** test/dpb_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Port checker, timing for the reset configuration
// ************************************************************
module dpb_checker (
    // Clock and reset
    input wire logic                 CLK,
    input wire logic                 RST_B,
    // Command and bus
    input wire dpb_pkg::dpb_req_type CMD_REQ,
    input wire logic                 HSEL,
    input wire logic [31:0]          HADDR,
    input wire logic [1:0]           HTRANS,
    input wire logic                 HWRITE,
    input wire logic [2:0]           HSIZE,
    input wire logic [31:0]          HWDATA,
    input wire logic                 HREADY,
    input wire logic [31:0]          HRDATA,
    input wire logic                 HREADYOUT,
    input wire logic                 HRESP,
    // Bank state
    input wire logic [3:0]           BANK_OPEN,
    input wire logic [3:0]           BANK_PRECHARGING
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    logic [1:0] ap_bank_reg;

    // Bank of the latest column command with auto-precharge
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) ap_bank_reg <= 2'h0;
        else if (CMD_REQ.ap_all && (CMD_REQ.cmd == dpb_pkg::CMD_RD
                 || CMD_REQ.cmd == dpb_pkg::CMD_WR)) ap_bank_reg <= CMD_REQ.bank;
    end

    sequence s_rd_ap; CMD_REQ.cmd == dpb_pkg::CMD_RD && CMD_REQ.ap_all; endsequence
    sequence s_wr_ap; CMD_REQ.cmd == dpb_pkg::CMD_WR && CMD_REQ.ap_all; endsequence
    sequence s_pre_one; CMD_REQ.cmd == dpb_pkg::CMD_PRE && !CMD_REQ.ap_all; endsequence
    sequence s_pre_all; CMD_REQ.cmd == dpb_pkg::CMD_PRE && CMD_REQ.ap_all; endsequence
    sequence s_act; CMD_REQ.cmd == dpb_pkg::CMD_ACT; endsequence
    sequence s_hole_rd; HSEL && HREADY && HTRANS[1] && !HWRITE && HADDR[7:0] == 8'h10; endsequence

    ready_always_a: assert property (HREADYOUT)
        else $error("bus stalled");
    resp_okay_a: assert property (!HRESP)
        else $error("bus error response");
    act_opens_a: assert property (s_act |-> ##2 BANK_OPEN[$past(CMD_REQ.bank, 2)])
        else $error("activate did not open bank");
    pre_one_close_a: assert property (s_pre_one |-> ##2 !BANK_OPEN[$past(CMD_REQ.bank, 2)])
        else $error("precharge left bank open");
    pre_others_keep_a: assert property (s_pre_one |-> ##2 ((BANK_OPEN ^ $past(BANK_OPEN, 1))
        & ~(4'h1 << $past(CMD_REQ.bank, 2))) == 4'h0) else $error("precharge hit other bank");
    pre_all_close_a: assert property (s_pre_all |-> ##2 BANK_OPEN == 4'h0)
        else $error("precharge all left a bank open");
    rd_ap_hold_a: assert property (s_rd_ap |=> BANK_OPEN[ap_bank_reg] [*5])
        else $error("read auto-precharge too early");
    wr_ap_hold_a: assert property (s_wr_ap |=> BANK_OPEN[ap_bank_reg] [*8])
        else $error("write auto-precharge too early");
    open_excl_a: assert property ((BANK_OPEN & BANK_PRECHARGING) == 4'h0)
        else $error("bank open and precharging");
    hole_zero_a: assert property (s_hole_rd |=> HRDATA == 32'h0)
        else $error("unmapped read not zero");
endmodule : dpb_checker

bind dpb_top dpb_checker u_chk (.CLK(CLK), .RST_B(RST_B), .CMD_REQ(CMD_REQ), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .BANK_OPEN(BANK_OPEN), .BANK_PRECHARGING(BANK_PRECHARGING));
`default_nettype wire

// *** test/test_dram_precharge_burst_interrupt.sv ***
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Bench: register bus and command sequences
// ************************************************************
module test_dram_precharge_burst_interrupt;
    localparam dpb_pkg::dpb_cmd_type RD = dpb_pkg::CMD_RD;
    localparam dpb_pkg::dpb_cmd_type WR = dpb_pkg::CMD_WR;
    localparam dpb_pkg::dpb_cmd_type PR = dpb_pkg::CMD_PRE;
    logic                 clk, rst_b, hsel, hwrite, hreadyout, hresp;
    logic [31:0]          haddr, hwdata, hrdata, v;
    logic [1:0]           htrans;
    logic [2:0]           hsize;
    logic [3:0]           bank_open, bank_prech, exp;
    dpb_pkg::dpb_req_type cmd_req;
    int                   mismatches, checks, cycles = 0;

    dpb_top uut (.CLK(clk), .RST_B(rst_b), .CMD_REQ(cmd_req), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .BANK_OPEN(bank_open),
        .BANK_PRECHARGING(bank_prech));
    dpb_ctrl_model ctrl (.CLK(clk), .CMD_REQ(cmd_req));

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Compare and count
    task check(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, want);
        end
    endtask : check

    task stop_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    // One AHB-Lite single word transfer
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h0, a};
        hsize <= 3'h2;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        q = hrdata;
    endtask : bus

    // Close every bank, then open all four with a settled row
    task reopen;
        ctrl.send(PR, 2'h0, 1'b1, 5);
        for (int b = 0; b < 4; b++) ctrl.send(dpb_pkg::CMD_ACT, b[1:0], 1'b0, (b == 3) ? 13 : 1);
    endtask : reopen

    // Two commands at a given spacing, then the masked violation flags
    task viol_case(input dpb_pkg::dpb_cmd_type c1, input logic ap1, input dpb_pkg::dpb_cmd_type c2,
                   input logic ap2, input logic [1:0] b2, input int gap, input logic [3:0] m,
                   input logic [3:0] want);
        reopen();
        bus(1'b1, 8'h0c, 32'hf, v);
        ctrl.send(c1, 2'h0, ap1, gap);
        ctrl.send(c2, b2, ap2, 13);
        bus(1'b0, 8'h0c, 32'h0, v);
        check({28'h0, v[3:0] & m}, {28'h0, want});
    endtask : viol_case

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            mismatches++;
            stop_test();
        end
    end

    // Main sequence
    initial begin
        rst_b = 1'b0;
        {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        mismatches = 0;
        checks = 0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        bus(1'b0, 8'h00, 32'h0, v);
        check(v, 32'h0000_3301);
        bus(1'b0, 8'h04, 32'h0, v);
        check(v, 32'h0c02_0309);
        bus(1'b0, 8'h0c, 32'h0, v);
        check(v, 32'h0);
        bus(1'b1, 8'h04, 32'h0c02_030a, v);
        bus(1'b0, 8'h04, 32'h0, v);
        check(v, 32'h0c02_030a);
        bus(1'b1, 8'h04, 32'h0c02_0309, v);
        bus(1'b1, 8'h08, 32'hff, v);
        bus(1'b0, 8'h08, 32'h0, v);
        check(v, 32'h0);
        bus(1'b0, 8'h10, 32'h0, v);
        check(v, 32'h0);
        $display("test registers done");
        reopen();
        check(bank_open, 4'hf);
        exp = 4'hf;
        for (int b = 0; b < 4; b++) begin
            ctrl.send(PR, b[1:0], 1'b0, 3);
            exp = exp & ~(4'h1 << b);
            check(bank_open, exp);
        end
        $display("test precharge select done");
        reopen();
        ctrl.send(RD, 2'h0, 1'b1, 6);
        check(bank_open[0], 1'b1);
        @(posedge clk);
        check(bank_open[0], 1'b0);
        ctrl.send(WR, 2'h2, 1'b1, 1 + ctrl.wr_to_pre(0, 3, 4, 3) + 1);
        check(bank_open[2], 1'b1);
        @(posedge clk);
        check(bank_open[2], 1'b0);
        ctrl.send(RD, 2'h1, 1'b0, 12);
        check(bank_open, 4'ha);
        ctrl.send(PR, 2'h3, 1'b0, 4);
        ctrl.send(dpb_pkg::CMD_ACT, 2'h3, 1'b0, 2);
        ctrl.send(RD, 2'h3, 1'b1, 9);
        check(bank_open[3], 1'b1);
        repeat (4) @(posedge clk);
        check(bank_open[3], 1'b0);
        // Precharge before the active minimum, activate before the precharge period
        bus(1'b1, 8'h0c, 32'hf, v);
        ctrl.send(dpb_pkg::CMD_ACT, 2'h3, 1'b0, 2);
        ctrl.send(PR, 2'h3, 1'b0, 2);
        ctrl.send(dpb_pkg::CMD_ACT, 2'h3, 1'b0, 3);
        bus(1'b0, 8'h0c, 32'h0, v);
        check(v, 32'hc);
        $display("test auto-precharge done");
        viol_case(RD, 1'b0, RD, 1'b1, 2'h1, 2, 4'h1, 4'h0);
        viol_case(RD, 1'b0, WR, 1'b0, 2'h0, 2, 4'h1, 4'h1);
        viol_case(WR, 1'b0, RD, 1'b0, 2'h0, 2, 4'h1, 4'h1);
        viol_case(RD, 1'b0, RD, 1'b0, 2'h0, 3, 4'h1, 4'h1);
        viol_case(RD, 1'b0, RD, 1'b0, 2'h0, 1, 4'h2, 4'h2);
        viol_case(RD, 1'b1, RD, 1'b0, 2'h1, 2, 4'h1, 4'h1);
        viol_case(RD, 1'b0, PR, 1'b0, 2'h0, ctrl.rd_to_pre(0, 4, 2) - 1, 4'h4, 4'h4);
        viol_case(RD, 1'b0, PR, 1'b0, 2'h0, ctrl.rd_to_pre(0, 4, 2), 4'h4, 4'h0);
        viol_case(WR, 1'b0, PR, 1'b0, 2'h0, ctrl.wr_to_pre(0, 3, 4, 3) - 1, 4'h4, 4'h4);
        viol_case(WR, 1'b0, PR, 1'b0, 2'h0, ctrl.wr_to_pre(0, 3, 4, 3), 4'h4, 4'h0);
        viol_case(RD, 1'b1, dpb_pkg::CMD_ACT, 1'b0, 2'h0, 2, 4'h8, 4'h8);
        viol_case(WR, 1'b1, dpb_pkg::CMD_ACT, 1'b0, 2'h0, 2, 4'h8, 4'h8);
        $display("test violations done");
        // Burst of four: any cut is illegal, precharge gap shrinks
        bus(1'b1, 8'h00, 32'h0000_3300, v);
        viol_case(RD, 1'b0, RD, 1'b0, 2'h1, 1, 4'h1, 4'h1);
        viol_case(RD, 1'b0, PR, 1'b0, 2'h0, ctrl.rd_to_pre(0, 2, 2), 4'h5, 4'h0);
        bus(1'b1, 8'h00, 32'h0000_3301, v);
        // Longer read-to-precharge pushes the auto-precharge out
        bus(1'b1, 8'h04, 32'h0c04_0309, v);
        reopen();
        ctrl.send(RD, 2'h0, 1'b1, 8);
        check(bank_open[0], 1'b1);
        @(posedge clk);
        check(bank_open[0], 1'b0);
        $display("test short burst and delayed auto-precharge done");
        stop_test();
    end
endmodule : test_dram_precharge_burst_interrupt
`default_nettype wire
